// ### rtl/ea_unit_pkg.sv
// Constants and types shared by the effective-address unit
package ea_unit_pkg;

  // Addressing modes
  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_DISP16,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_ABS8,
    MODE_ABS16,
    MODE_IMM8,
    MODE_IMM16,
    MODE_PC_REL,
    MODE_MEM_INDIRECT,
    MODE_NONE
  } ea_mode_t;

  // Instruction classes that constrain the legal modes
  typedef enum logic [3:0] {
    CLS_MOVE_BYTE,
    CLS_MOVE_WORD,
    CLS_ARITH_BYTE,
    CLS_ARITH_BYTE_IMM,
    CLS_ARITH_WORD,
    CLS_SMALL_ADDSUB,
    CLS_MUL_DIV,
    CLS_BIT_OP,
    CLS_BIT_OP_REGNUM,
    CLS_BRANCH_REL,
    CLS_JUMP,
    CLS_FLAG_PUSH,
    CLS_FLAG_POP
  } ins_class_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ_PTR,
    ST_DONE
  } ea_state_t;

  // Fixed page values for short addresses
  localparam logic [7:0]  ABS8_PAGE     = 8'hff;
  localparam logic [7:0]  INDIRECT_PAGE = 8'h00;
  // Step sizes for auto increment and decrement
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  // Small add and subtract immediates
  localparam logic [15:0] SMALL_IMM_ONE = 16'h0001;
  localparam logic [15:0] SMALL_IMM_TWO = 16'h0002;
  // Bit-number field position within its byte
  localparam int          BITNUM_LSB    = 4;
  localparam int          BITNUM_WIDTH  = 3;
  // Reset values
  localparam logic [15:0] ADDR_RESET    = 16'h0000;

endpackage : ea_unit_pkg

// ### rtl/effective_address_unit.sv
// Effective-address generation and memory operand formatting
`timescale 1ns/1ps
module effective_address_unit
  import ea_unit_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // Request from decode stage
  input  wire logic        i_req,           // One-cycle start pulse
  input  wire ea_mode_t    i_mode,          // Addressing mode
  input  wire ins_class_t  i_class,         // Instruction class
  input  wire logic        i_small_two,     // Small add/sub uses two
  input  wire logic        i_bitnum_byte4,  // Bit number in fourth byte
  input  wire logic [7:0]  i_byte2,         // Second instruction byte
  input  wire logic [7:0]  i_byte3,         // Third instruction byte
  input  wire logic [7:0]  i_byte4,         // Fourth instruction byte
  input  wire logic [15:0] i_reg_value,     // Selected register contents
  input  wire logic [15:0] i_pc,            // Program counter
  input  wire logic [7:0]  i_flags,         // Flag register for a push
  // Code fetch alignment request
  input  wire logic        i_fetch_req,     // Fetch address valid
  input  wire logic [15:0] i_fetch_addr,    // Raw fetch address
  // Memory read answer for pointer fetch
  input  wire logic        i_mem_ack,       // Read data valid
  input  wire logic [15:0] i_mem_rdata,     // Big-endian word read
  // Results to memory and fetch bus
  output logic             o_done,          // Result valid pulse
  output logic             o_illegal,       // Mode not allowed pulse
  output logic             o_mem_access,    // Result addresses memory
  output logic [15:0]      o_addr,          // Operand or branch address
  output logic             o_is_branch,     // Address is a branch target
  output logic             o_word,          // Operand is a word
  output logic [15:0]      o_imm,           // Immediate operand
  output logic [2:0]       o_bitnum,        // Bit position
  output logic             o_reg_wide,      // Register field is 16-bit
  output logic             o_reg_we,        // Write back updated register
  output logic [15:0]      o_reg_new,       // Updated register value
  output logic [15:0]      o_push_data,     // Formatted flag word
  output logic [7:0]       o_pop_flags,     // Restored flag byte
  output logic             o_ptr_rd,        // Pointer read request
  output logic [15:0]      o_ptr_addr,      // Pointer read address
  output logic             o_fetch_valid,   // Aligned fetch valid
  output logic [15:0]      o_fetch_addr     // Aligned fetch address
);

  // Odd addresses are rounded down, not trapped;
  // software relying on an odd word sees the one before.
  // Shared by words, fetches and branch targets
  // Clear bit zero of a word address
  function automatic logic [15:0] align_even(input logic [15:0] a);
    align_even = {a[15:1], 1'b0};
  endfunction : align_even

  // Only memory indirect takes more than one cycle;
  // every other mode answers on the next edge
  // Sequencer state
  ea_state_t   state_reg;             // Current state
  ea_state_t   state_next;            // Next state
  // Kept while a pointer read is outstanding
  // Latched request
  logic [15:0] addr_reg;              // Held pointer address
  logic        word_reg;              // Held size

  // Decoding is combinational from the request inputs,
  // which need only stand in the cycle of i_req
  // Decoded per-class properties
  wire logic   cls_is_word;           // Class works on words
  wire logic   cls_wide_reg;          // Register field selects 16 bits
  wire logic   mode_ok;               // Mode legal for class
  wire logic   is_branch;             // Result is a branch target
  wire logic   is_mem;                // Result addresses memory
  wire logic   step_mode;             // Auto increment or decrement
  wire logic [15:0] step;             // Step size
  wire logic [15:0] disp_sext;        // Sign-extended branch offset
  wire logic [15:0] raw_addr;         // Address before alignment
  wire logic [15:0] final_addr;       // Address after alignment
  wire logic [15:0] imm_val;          // Immediate value
  wire logic [15:0] reg_new;          // Register after step
  wire logic [7:0]  bit_src;          // Byte carrying bit number
  logic        mode_ok_c;             // Table output

  // Size sets the auto step and the alignment
  // Word-sized classes
  assign cls_is_word  = (i_class == CLS_MOVE_WORD) || (i_class == CLS_FLAG_PUSH)
                     || (i_class == CLS_FLAG_POP);
  // Register width follows the class, not the mode
  // Wide register selection for word operations
  assign cls_wide_reg = (i_class == CLS_MOVE_WORD) || (i_class == CLS_ARITH_WORD)
                     || (i_class == CLS_SMALL_ADDSUB) || (i_class == CLS_MUL_DIV);

  // Refuse rather than guess: a mode outside its class
  // gives the illegal pulse and leaves data outputs alone,
  // so a stale address is never taken for a fresh one.
  // Flag stacking uses the stack modes and is word sized,
  // so the stack pointer never goes odd
  // Legal mode table; each class allows only a subset
  always_comb begin
    case (i_class)
      // Short absolute yes, long immediate no
      // Byte moves: all but relative, memory indirect and long immediate
      CLS_MOVE_BYTE: begin
        mode_ok_c = !(i_mode inside {MODE_PC_REL, MODE_MEM_INDIRECT, MODE_IMM16,
                                     MODE_NONE});
      end
      // Long immediate kept
      // Word moves: all but relative, memory indirect and short absolute
      CLS_MOVE_WORD: begin
        mode_ok_c = !(i_mode inside {MODE_PC_REL, MODE_MEM_INDIRECT, MODE_ABS8,
                                     MODE_NONE});
      end
      // Register width comes from the class table
      // Plain arithmetic on registers
      CLS_ARITH_BYTE, CLS_ARITH_WORD, CLS_SMALL_ADDSUB, CLS_MUL_DIV: begin
        mode_ok_c = (i_mode == MODE_REG_DIRECT);
      end
      // Byte arithmetic and logic also with short immediate
      CLS_ARITH_BYTE_IMM: begin
        mode_ok_c = (i_mode == MODE_REG_DIRECT) || (i_mode == MODE_IMM8);
      end
      // Bit number source leaves operand modes alone
      // Bit operations
      CLS_BIT_OP, CLS_BIT_OP_REGNUM: begin
        mode_ok_c = i_mode inside {MODE_REG_DIRECT, MODE_REG_INDIRECT, MODE_ABS8};
      end
      // Reach set by the signed byte; evenness is the code's
      // Relative branches
      CLS_BRANCH_REL: begin
        mode_ok_c = (i_mode == MODE_PC_REL);
      end
      // No displacement or auto modes for jumps
      // Jumps: indirect, long absolute, memory indirect
      CLS_JUMP: begin
        mode_ok_c = i_mode inside {MODE_REG_INDIRECT, MODE_ABS16,
                                   MODE_MEM_INDIRECT};
      end
      // Push below the stack, pop from it
      // Flag stacking through the stack register
      CLS_FLAG_PUSH: begin
        mode_ok_c = (i_mode == MODE_PRE_DEC);
      end
      // Pop mirrors the push
      CLS_FLAG_POP: begin
        mode_ok_c = (i_mode == MODE_POST_INC);
      end
      default: begin
        mode_ok_c = 1'b0;
      end
    endcase
  end
  // Table result for sequencer and result block
  assign mode_ok = mode_ok_c;

  // Adders wrap at 16 bits; an offset past the top
  // rolls over to the bottom and needs no carry out.
  // Sign extension copies bit seven upward.
  // Pre-decrement addresses the new value,
  // post-increment the old one
  // Address source selection
  assign disp_sext = {{8{i_byte2[7]}}, i_byte2};
  assign step      = cls_is_word ? STEP_WORD : STEP_BYTE;
  assign step_mode = (i_mode == MODE_POST_INC) || (i_mode == MODE_PRE_DEC);
  assign reg_new   = (i_mode == MODE_POST_INC) ? i_reg_value + step
                                               : i_reg_value - step;
  assign raw_addr  = (i_mode == MODE_DISP16) ? i_reg_value + {i_byte3, i_byte4}
                   : (i_mode == MODE_PRE_DEC) ? reg_new
                   : (i_mode == MODE_ABS8)    ? {ABS8_PAGE, i_byte2}
                   : (i_mode == MODE_ABS16)   ? {i_byte3, i_byte4}
                   : (i_mode == MODE_PC_REL)  ? i_pc + disp_sext
                   : i_reg_value;
  // Branch classes never address data
  assign is_branch = (i_class == CLS_BRANCH_REL) || (i_class == CLS_JUMP);
  assign is_mem    = !is_branch && (i_mode inside {MODE_REG_INDIRECT, MODE_DISP16,
                     MODE_POST_INC, MODE_PRE_DEC, MODE_ABS8, MODE_ABS16});
  // Byte operands keep bit zero
  // Words and branch targets land on even addresses
  assign final_addr = (cls_is_word || is_branch) ? align_even(raw_addr)
                                                 : raw_addr;
  // Small add and subtract have no immediate field;
  // one opcode bit, i_small_two, picks 1 or 2
  // Immediate value selection
  assign imm_val = (i_class == CLS_SMALL_ADDSUB)
                   ? (i_small_two ? SMALL_IMM_TWO : SMALL_IMM_ONE)
                 : (i_mode == MODE_IMM16) ? {i_byte3, i_byte4}
                 : {8'h00, i_byte2};
  // Register-held bit numbers are left to execution;
  // only the immediate form is decoded here
  // Bit number from second or fourth byte
  assign bit_src = i_bitnum_byte4 ? i_byte4 : i_byte2;

  // Two working states; the two spare codes, ST_DONE included, fall to idle
  // through the default branch, so a bad state
  // recovers on the next edge instead of hanging
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Idle until a legal request arrives
      // Memory indirect needs a pointer read first
      ST_IDLE: begin
        if (i_req && mode_ok && (i_mode == MODE_MEM_INDIRECT)) begin
          state_next = ST_READ_PTR;
        end
      end
      // No limit on latency; the bus must answer
      // Wait for the pointer word
      ST_READ_PTR: begin
        if (i_mem_ack) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Synchronous reset, like every register here
  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // All outputs registered: clean levels one cycle after the request,
  // or one cycle after the pointer answer for memory indirect. Pulses default low each edge.
  // A request during a pointer read is dropped
  // silently; decode must wait for done
  // Result outputs; pulses last one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      // Outputs and held state return to zero
      o_done      <= 1'b0;
      o_illegal   <= 1'b0;
      o_mem_access<= 1'b0;
      o_addr      <= ADDR_RESET;
      o_is_branch <= 1'b0;
      o_word      <= 1'b0;
      o_imm       <= 16'h0000;
      o_bitnum    <= 3'h0;
      o_reg_wide  <= 1'b0;
      o_reg_we    <= 1'b0;
      o_reg_new   <= 16'h0000;
      o_push_data <= 16'h0000;
      o_pop_flags <= 8'h00;
      o_ptr_rd    <= 1'b0;
      o_ptr_addr  <= ADDR_RESET;
      // Held pointer request
      word_reg    <= 1'b0;
      addr_reg    <= ADDR_RESET;
    end else begin
      // Pulses low unless set below
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      o_reg_we  <= 1'b0;
      o_ptr_rd  <= 1'b0;
      // New request, taken with no pointer read pending
      if (state_reg == ST_IDLE && i_req) begin
        if (!mode_ok) begin
          // Refuse modes outside the class subset
          o_illegal <= 1'b1;
        end else if (i_mode == MODE_MEM_INDIRECT) begin
          // Pointer sits in page zero, read as a word
          o_ptr_rd   <= 1'b1;
          o_ptr_addr <= align_even({INDIRECT_PAGE, i_byte2});
          addr_reg   <= align_even({INDIRECT_PAGE, i_byte2});
          word_reg   <= 1'b1;
        end else begin
          // Single-cycle answer; the push word is formed
          // and stored on every single-cycle answer, not only a flag push,
          // and write-back happens only in the auto modes
          o_done       <= 1'b1;
          o_addr       <= final_addr;
          o_mem_access <= is_mem;
          o_is_branch  <= is_branch;
          o_word       <= cls_is_word;
          o_imm        <= imm_val;
          o_bitnum     <= bit_src[BITNUM_LSB +: BITNUM_WIDTH];
          o_reg_wide   <= cls_wide_reg;
          o_reg_we     <= step_mode;
          o_reg_new    <= reg_new;
          o_push_data  <= {i_flags, i_flags};
        end
      // Pointer answer closes the indirect request
      end else if (state_reg == ST_READ_PTR && i_mem_ack) begin
        // Size is the held word size; width is narrow, as for a jump
        // Pointer word becomes the even branch target
        o_done       <= 1'b1;
        o_addr       <= align_even(i_mem_rdata);
        o_is_branch  <= 1'b1;
        o_mem_access <= 1'b0;
        o_word       <= word_reg;
        o_reg_wide   <= 1'b0;
      end
      // Any read answer refreshes the restored flags;
      // the odd byte copy is ignored on purpose
      // Restored flags come from the even (upper) byte only
      if (i_mem_ack) begin
        o_pop_flags <= i_mem_rdata[15:8];
      end
    end
  end

  // Fetch path runs beside the decoder, never stalls;
  // it rounds down and delays by one cycle
  // Code fetch alignment path
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_fetch_valid <= 1'b0;
      o_fetch_addr  <= ADDR_RESET;
    end else begin
      // Valid follows the request one cycle late
      o_fetch_valid <= i_fetch_req;
      o_fetch_addr  <= align_even(i_fetch_addr);
    end
  end

endmodule : effective_address_unit

// ### testbench/ea_unit_properties.sv
// Concurrent checks on the effective-address unit ports
`timescale 1ns/1ps
module ea_unit_properties
  import ea_unit_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  // Decode side
  input wire logic        i_req,
  input wire ea_mode_t    i_mode,
  input wire ins_class_t  i_class,
  input wire logic [7:0]  i_byte2,
  input wire logic [7:0]  i_byte3,
  input wire logic [7:0]  i_byte4,
  input wire logic [15:0] i_reg_value,
  input wire logic [15:0] i_pc,
  input wire logic [7:0]  i_flags,
  input wire logic        i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  input wire logic        i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // Results
  input wire logic        o_done,
  input wire logic        o_illegal,
  input wire logic [15:0] o_addr,
  input wire logic        o_is_branch,
  input wire logic        o_reg_we,
  input wire logic [15:0] o_reg_new,
  input wire logic [15:0] o_push_data,
  input wire logic [7:0]  o_pop_flags,
  input wire logic        o_ptr_rd,
  input wire logic [15:0] o_ptr_addr,
  input wire logic        o_fetch_valid,
  input wire logic [15:0] o_fetch_addr
);
  logic [15:0] disp_sum;  // Register plus long displacement
  logic [15:0] rel_sum;   // Counter plus signed short offset
  assign disp_sum = i_reg_value + {i_byte3, i_byte4};
  assign rel_sum  = i_pc + {{8{i_byte2[7]}}, i_byte2};

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // Pointer fetch is two steps: request, then page-zero read
  sequence s_ptr_req;
    i_req && i_mode == MODE_MEM_INDIRECT && i_class == CLS_JUMP;
  endsequence
  sequence s_ptr_issue;
    o_ptr_rd && o_ptr_addr == {8'h00, $past(i_byte2[7:1]), 1'b0};
  endsequence

  a_ptr_issue: assert property (s_ptr_req |=> s_ptr_issue)
    else $error("pointer read address wrong");
  a_ptr_target: assert property (i_mem_ack |=> o_done && o_is_branch
    && o_addr == {$past(i_mem_rdata[15:1]), 1'b0}) else $error("indirect target wrong");
  a_pop_upper: assert property (i_mem_ack |=> o_pop_flags == $past(i_mem_rdata[15:8]))
    else $error("restored flags not upper byte");
  a_fetch_even: assert property (i_fetch_req |=> o_fetch_valid
    && o_fetch_addr == {$past(i_fetch_addr[15:1]), 1'b0}) else $error("fetch not aligned");
  a_disp_even: assert property (i_req && i_mode == MODE_DISP16 && i_class == CLS_MOVE_WORD
    |=> o_done && o_addr == {$past(disp_sum[15:1]), 1'b0}) else $error("displacement wrong");
  a_post_step: assert property (i_req && i_mode == MODE_POST_INC && i_class == CLS_MOVE_BYTE
    |=> o_reg_we && o_addr == $past(i_reg_value)
    && o_reg_new == $past(i_reg_value) + 16'h0001) else $error("post increment wrong");
  a_pre_step: assert property (i_req && i_mode == MODE_PRE_DEC && i_class == CLS_MOVE_WORD
    |=> o_reg_we && o_addr == o_reg_new
    && o_reg_new == $past(i_reg_value) - 16'h0002) else $error("pre decrement wrong");
  a_abs8_page: assert property (i_req && i_mode == MODE_ABS8 && i_class == CLS_BIT_OP
    |=> o_done && o_addr == {8'hff, $past(i_byte2)}) else $error("short absolute page wrong");
  a_rel_target: assert property (i_req && i_mode == MODE_PC_REL && i_class == CLS_BRANCH_REL
    |=> o_is_branch && o_addr == {$past(rel_sum[15:1]), 1'b0})
    else $error("relative target wrong");
  a_push_dup: assert property (i_req && i_mode == MODE_PRE_DEC && i_class == CLS_FLAG_PUSH
    |=> o_push_data == {2{$past(i_flags)}}) else $error("flag push word wrong");
  a_imm16_refused: assert property (i_req && i_mode == MODE_IMM16
    && i_class == CLS_MOVE_BYTE |=> o_illegal && !o_done)
    else $error("long immediate byte move accepted");
endmodule : ea_unit_properties

// ### testbench/mem_model.sv
// Memory model answering pointer reads after a chosen latency
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Pointer read request and latency
  input  wire logic        i_ptr_rd,
  input  wire logic [15:0] i_ptr_addr,
  input  wire logic [3:0]  i_lat,
  // Read answer
  output logic             o_mem_ack,
  output logic [15:0]      o_mem_rdata
);
  logic [3:0]  wait_cnt = 4'h0;     // Cycles left before answer
  logic        pending  = 1'b0;     // Read outstanding
  logic [15:0] ptr_hold = 16'h0000; // Latched read address
  initial o_mem_ack = 1'b0;
  initial o_mem_rdata = 16'h0000;
  // Byte contents derived from address, so no storage needed
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ 8'h96;
  endfunction : byte_at
  // Answer one read; data toggles when released so stale values never match
  always @(posedge i_clk_sys) begin
    o_mem_ack <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    if (i_ptr_rd) begin
      pending <= 1'b1;
      wait_cnt <= i_lat;
      ptr_hold <= i_ptr_addr;
    end else if (pending && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pending) begin
      pending <= 1'b0;
      o_mem_ack <= 1'b1;
      o_mem_rdata <= {byte_at(ptr_hold), byte_at(ptr_hold | 16'h0001)};
    end
  end
endmodule : mem_model

// ### testbench/test_effective_address_unit.sv
// Self-checking bench for the effective-address unit
`timescale 1ns/1ps
module test_effective_address_unit;
  import ea_unit_pkg::*;
  logic i_clk_sys, i_resetn, i_req, i_small_two, i_bitnum_byte4, i_fetch_req, i_mem_ack;
  ea_mode_t i_mode;
  ins_class_t i_class;
  logic [7:0] i_byte2, i_byte3, i_byte4, i_flags, o_pop_flags;
  logic [15:0] i_reg_value, i_pc, i_fetch_addr, i_mem_rdata, o_addr, o_imm, o_reg_new;
  logic [15:0] o_push_data, o_ptr_addr, o_fetch_addr;
  logic o_done, o_illegal, o_mem_access, o_is_branch, o_word, o_reg_wide, o_reg_we;
  logic o_ptr_rd, o_fetch_valid;
  logic [2:0] o_bitnum;
  logic [3:0] lat;  // Memory answer latency
  int fail_count, num_checks;

  effective_address_unit u_dut (.i_clk_sys, .i_resetn, .i_req, .i_mode, .i_class,
    .i_small_two, .i_bitnum_byte4, .i_byte2, .i_byte3, .i_byte4, .i_reg_value, .i_pc,
    .i_flags, .i_fetch_req, .i_fetch_addr, .i_mem_ack, .i_mem_rdata, .o_done, .o_illegal,
    .o_mem_access, .o_addr, .o_is_branch, .o_word, .o_imm, .o_bitnum, .o_reg_wide,
    .o_reg_we, .o_reg_new, .o_push_data, .o_pop_flags, .o_ptr_rd, .o_ptr_addr,
    .o_fetch_valid, .o_fetch_addr);
  mem_model u_mem (.i_clk_sys, .i_ptr_rd(o_ptr_rd), .i_ptr_addr(o_ptr_addr), .i_lat(lat),
    .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One request; byte2 doubles as flag value, sel picks small two and byte4 bit number
  task automatic issue(input ea_mode_t m, input ins_class_t c, input logic [7:0] b2, b3, b4,
                       input logic [15:0] rv, input logic [1:0] sel);
    int n;
    @(posedge i_clk_sys);
    i_req <= 1'b1;
    i_mode <= m;
    i_class <= c;
    {i_byte2, i_byte3, i_byte4, i_flags} <= {b2, b3, b4, b2};
    {i_reg_value, i_pc} <= {rv, rv};
    {i_small_two, i_bitnum_byte4} <= sel;
    @(posedge i_clk_sys);
    i_req <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clk_sys);
      if (o_done === 1'b1 || o_illegal === 1'b1) break;
    end
    if (n == 40) begin
      fail_count++;
      print_verdict();
    end
  endtask : issue

  task automatic t_indirect();
    issue(MODE_DISP16, CLS_MOVE_WORD, 8'h00, 8'h00, 8'h03, 16'h1000, 2'b00);
    check("disp_addr", 16'h1002, o_addr);
    check("disp_word", 16'h0001, {15'h0000, o_word});
    check("disp_mem", 16'h0001, {15'h0000, o_mem_access});
    issue(MODE_POST_INC, CLS_MOVE_BYTE, 8'h00, 8'h00, 8'h00, 16'h1235, 2'b00);
    check("post_b_new", 16'h1236, o_reg_new);
    issue(MODE_POST_INC, CLS_MOVE_WORD, 8'h00, 8'h00, 8'h00, 16'h2000, 2'b00);
    check("post_w_new", 16'h2002, o_reg_new);
    issue(MODE_PRE_DEC, CLS_MOVE_BYTE, 8'h00, 8'h00, 8'h00, 16'h3000, 2'b00);
    check("pre_b_addr", 16'h2fff, o_addr);
    issue(MODE_PRE_DEC, CLS_MOVE_WORD, 8'h00, 8'h00, 8'h00, 16'h3002, 2'b00);
    check("pre_w_addr", 16'h3000, o_addr);
    issue(MODE_PRE_DEC, CLS_FLAG_PUSH, 8'ha7, 8'h00, 8'h00, 16'h4000, 2'b00);
    check("push_word", 16'ha7a7, o_push_data);
    check("push_sp", 16'h3ffe, o_reg_new);
    issue(MODE_POST_INC, CLS_FLAG_POP, 8'h00, 8'h00, 8'h00, 16'h5000, 2'b00);
    check("pop_sp", 16'h5002, o_reg_new);
    check("pop_addr", 16'h5000, o_addr);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_abs_imm();
    issue(MODE_ABS8, CLS_MOVE_BYTE, 8'h3c, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("abs8", 16'hff3c, o_addr);
    issue(MODE_ABS16, CLS_JUMP, 8'h00, 8'h12, 8'h35, 16'h0000, 2'b00);
    check("abs16", 16'h1234, o_addr);
    check("abs16_br", 16'h0001, {15'h0000, o_is_branch});
    check("abs16_mem", 16'h0000, {15'h0000, o_mem_access});
    issue(MODE_IMM8, CLS_MOVE_BYTE, 8'h9d, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("imm8", 16'h009d, o_imm);
    issue(MODE_IMM16, CLS_MOVE_WORD, 8'h00, 8'hbe, 8'hef, 16'h0000, 2'b00);
    check("imm16", 16'hbeef, o_imm);
    issue(MODE_REG_DIRECT, CLS_SMALL_ADDSUB, 8'h00, 8'h00, 8'h00, 16'h0000, 2'b10);
    check("small_two", 16'h0002, o_imm);
    check("wide_small", 16'h0001, {15'h0000, o_reg_wide});
    issue(MODE_REG_DIRECT, CLS_SMALL_ADDSUB, 8'h00, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("small_one", 16'h0001, o_imm);
    issue(MODE_REG_DIRECT, CLS_BIT_OP, 8'h50, 8'h00, 8'h30, 16'h0000, 2'b00);
    check("bit_b2", 16'h0005, {13'h0000, o_bitnum});
    check("wide_bit", 16'h0000, {15'h0000, o_reg_wide});
    issue(MODE_REG_DIRECT, CLS_BIT_OP, 8'h50, 8'h00, 8'h30, 16'h0000, 2'b01);
    check("bit_b4", 16'h0003, {13'h0000, o_bitnum});
    issue(MODE_REG_DIRECT, CLS_MUL_DIV, 8'h00, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("wide_mul", 16'h0001, {15'h0000, o_reg_wide});
    $display("test abs_imm done");
  endtask : t_abs_imm

  task automatic t_branch();
    issue(MODE_PC_REL, CLS_BRANCH_REL, 8'h80, 8'h00, 8'h00, 16'h1000, 2'b00);
    check("rel_back", 16'h0f80, o_addr);
    issue(MODE_PC_REL, CLS_BRANCH_REL, 8'h7e, 8'h00, 8'h00, 16'h1001, 2'b00);
    check("rel_odd", 16'h107e, o_addr);
    lat = 4'h0;
    issue(MODE_MEM_INDIRECT, CLS_JUMP, 8'h21, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("ind_fast", 16'hb6b6, o_addr);
    lat = 4'h6;
    issue(MODE_MEM_INDIRECT, CLS_JUMP, 8'h40, 8'h00, 8'h00, 16'h0000, 2'b00);
    check("ind_slow", 16'hd6d6, o_addr);
    check("pop_flags", 16'h00d6, {8'h00, o_pop_flags});
    $display("test branch done");
  endtask : t_branch

  task automatic t_legality();
    ea_mode_t   lm [10] = '{MODE_IMM8, MODE_IMM8, MODE_PC_REL, MODE_MEM_INDIRECT, MODE_ABS8,
      MODE_DISP16, MODE_ABS8, MODE_IMM16, MODE_REG_INDIRECT, MODE_REG_INDIRECT};
    ins_class_t lc [10] = '{CLS_ARITH_BYTE, CLS_ARITH_BYTE_IMM, CLS_MOVE_BYTE, CLS_MOVE_WORD,
      CLS_BIT_OP, CLS_BIT_OP, CLS_MOVE_WORD, CLS_MOVE_BYTE, CLS_BIT_OP_REGNUM, CLS_ARITH_WORD};
    logic [9:0] bad = 10'h2ed;  // Entries expected to be refused
    for (int i = 0; i < 10; i++) begin
      issue(lm[i], lc[i], 8'h00, 8'h00, 8'h00, 16'h1000, 2'b00);
      check("illegal", {15'h0000, bad[i]}, {15'h0000, o_illegal});
    end
    $display("test legality done");
  endtask : t_legality

  task automatic t_fetch();
    @(posedge i_clk_sys);
    i_fetch_req <= 1'b1;
    i_fetch_addr <= 16'h0101;
    @(posedge i_clk_sys);
    i_fetch_req <= 1'b0;
    @(negedge i_clk_sys);
    check("fetch_addr", 16'h0100, o_fetch_addr);
    check("fetch_valid", 16'h0001, {15'h0000, o_fetch_valid});
    $display("test fetch done");
  endtask : t_fetch

  // 100 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Main sequence
  initial begin
    {i_resetn, i_req, i_small_two, i_bitnum_byte4, i_fetch_req} = '0;
    {i_byte2, i_byte3, i_byte4, i_flags} = '0;
    {i_reg_value, i_pc, i_fetch_addr} = '0;
    i_mode = MODE_NONE;
    i_class = CLS_MOVE_BYTE;
    lat = 4'h0;
    repeat (20) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    t_indirect();
    t_abs_imm();
    t_branch();
    t_legality();
    t_fetch();
    print_verdict();
  end
endmodule : test_effective_address_unit

bind effective_address_unit ea_unit_properties u_props (.i_clk_sys, .i_resetn, .i_req,
  .i_mode, .i_class, .i_byte2, .i_byte3, .i_byte4, .i_reg_value, .i_pc, .i_flags,
  .i_fetch_req, .i_fetch_addr, .i_mem_ack, .i_mem_rdata, .o_done, .o_illegal, .o_addr,
  .o_is_branch, .o_reg_we, .o_reg_new, .o_push_data, .o_pop_flags, .o_ptr_rd,
  .o_ptr_addr, .o_fetch_valid, .o_fetch_addr);
